/* File: cbc_pkg.sv */
// Purpose: shared constants, types and decode functions for the cpu bus cycle ends
// Assumes: one 100 MHz core clock; bus strobes are active low
// Notes:   machine cycle and t-state types are one-hot
package cbc_pkg;

  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 8;
  localparam int ROW_W        = 7;
  localparam int ROM_ADDR_BIT = 15;

  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  IPAGE_RESET = 8'h00;
  localparam logic [7:0]  ROW_RESET   = 8'h00;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [1:0]  IM_RESET    = 2'h0;
  localparam logic [1:0]  SLOT_RESET  = 2'h0;
  localparam logic [1:0]  SLOT_BOOT   = 2'h0;
  localparam logic [2:0]  MCYC_FETCH  = 3'h0;
  localparam logic [2:0]  MCYC_OPND1  = 3'h1;
  localparam logic [2:0]  MCYC_OPND2  = 3'h2;
  localparam logic [2:0]  MCYC_DATA   = 3'h3;

  // opcodes that the sequencer knows; any other opcode runs in one machine cycle
  localparam logic [7:0] OP_LD_A_ABS = 8'h3a;
  localparam logic [7:0] OP_LD_ABS_A = 8'h32;
  localparam logic [7:0] OP_IN_A     = 8'hdb;
  localparam logic [7:0] OP_OUT_A    = 8'hd3;
  localparam logic [7:0] OP_EI       = 8'hfb;
  localparam logic [7:0] OP_DI       = 8'hf3;

  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int POR_TIME_MS = 200;
  localparam int POR_CYCLES  = POR_TIME_MS * (CLK_FREQ_HZ / 1000);

  typedef enum logic [3:0]
  {
    T1 = 4'h1,
    T2 = 4'h2,
    T3 = 4'h4,
    T4 = 4'h8
  } cbc_tstate_t;

  typedef enum logic [5:0]
  {
    MC_FETCH   = 6'h01,
    MC_MEM_RD  = 6'h02,
    MC_MEM_WR  = 6'h04,
    MC_IO_RD   = 6'h08,
    MC_IO_WR   = 6'h10,
    MC_INT_ACK = 6'h20
  } cbc_mcycle_t;

  function automatic logic [2:0] cbc_cycle_count(input logic [7:0] op);
    case (op)
      OP_LD_A_ABS: cbc_cycle_count = 3'h4;
      OP_LD_ABS_A: cbc_cycle_count = 3'h4;
      OP_IN_A:     cbc_cycle_count = 3'h3;
      OP_OUT_A:    cbc_cycle_count = 3'h3;
      default:     cbc_cycle_count = 3'h1;
    endcase
  endfunction

  function automatic cbc_mcycle_t cbc_cycle_kind(input logic [7:0] op, input logic [2:0] idx);
    cbc_cycle_kind = MC_MEM_RD;
    case (op)
      OP_LD_ABS_A: if (idx == MCYC_DATA) cbc_cycle_kind = MC_MEM_WR;
      OP_IN_A:     if (idx == MCYC_OPND2) cbc_cycle_kind = MC_IO_RD;
      OP_OUT_A:    if (idx == MCYC_OPND2) cbc_cycle_kind = MC_IO_WR;
      default:     cbc_cycle_kind = MC_MEM_RD;
    endcase
  endfunction

endpackage

/* File: cbc_bus_if.sv */
// Purpose: control, address and data bus between the cpu end and the controller end
// Assumes: data wire resolved here from the two output enables
// Notes:   undriven data reads as all ones
`timescale 1ns/1ns
interface cbc_bus_if;
  import cbc_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] cpu_data;
  logic              cpu_data_oe;
  logic [DATA_W-1:0] ctl_data;
  logic              ctl_data_oe;
  logic [DATA_W-1:0] data;
  logic              opcode_fetch_n;
  logic              memory_request_n;
  logic              io_request_n;
  logic              read_n;
  logic              store_strobe_n;
  logic              refresh_cycle_n;
  logic              wait_n;
  logic              sys_reset_n;

  assign data = cpu_data_oe ? cpu_data : (ctl_data_oe ? ctl_data : {DATA_W{1'b1}});

  modport cpu_end
  (
    output addr, cpu_data, cpu_data_oe, opcode_fetch_n, memory_request_n, io_request_n,
    output read_n, store_strobe_n, refresh_cycle_n,
    input  data, wait_n, sys_reset_n
  );

  modport ctl_end
  (
    input  addr, data, opcode_fetch_n, memory_request_n, io_request_n,
    input  read_n, store_strobe_n, refresh_cycle_n,
    output ctl_data, ctl_data_oe, wait_n, sys_reset_n
  );
endinterface

/* File: cbc_wait_gen.sv */
// Purpose: one stall state per opcode fetch, derived from the fetch strobe
// Assumes: fetch strobe sampled on the rising edge
// Notes:   wait is low for exactly one clock after the fetch strobe falls
`timescale 1ns/1ns
module cbc_wait_gen
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic opcode_fetch_n_i,
  output logic      wait_n_o
);
  import cbc_pkg::*;

  logic fetch_prev_reg;
  logic fetch_prev_next;
  logic wait_n_reg;
  logic wait_n_next;

  always_comb
  begin
    fetch_prev_next = opcode_fetch_n_i;
    wait_n_next     = ~(fetch_prev_reg & ~opcode_fetch_n_i);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fetch_prev_reg <= 1'b1;
      wait_n_reg     <= 1'b1;
    end
    else
    begin
      fetch_prev_reg <= fetch_prev_next;
      wait_n_reg     <= wait_n_next;
    end
  end

  assign wait_n_o = wait_n_reg;
endmodule

/* File: cbc_ctl_end.sv */
// Purpose: memory slot controller end: power-on reset, slot select, decode, data supply, wait
// Assumes: bus strobes settle within the cycle they change
// Notes:   write captures appear one clock after the store strobe falls
`timescale 1ns/1ns
module cbc_ctl_end #(
  parameter int POR_CYCLES = cbc_pkg::POR_CYCLES
)
(
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_i,
  cbc_bus_if.ctl_end                     bus,
  input  wire logic [1:0]                slot_sel_i,
  input  wire logic                      slot_load_i,
  input  wire logic [cbc_pkg::DATA_W-1:0] rdata_i,
  input  wire logic [cbc_pkg::DATA_W-1:0] int_vector_i,
  output logic [1:0]                     slot_select_o,
  output logic                           boot_rom_select_n_o,
  output logic                           mem_select_n_o,
  output logic                           io_select_n_o,
  output logic                           buffer_toward_cpu_o,
  output logic                           ppi_reset_o,
  output logic                           int_ack_o,
  output logic                           write_valid_o,
  output logic                           write_is_io_o,
  output logic [cbc_pkg::ADDR_W-1:0]     write_addr_o,
  output logic [cbc_pkg::DATA_W-1:0]     write_data_o
);
  import cbc_pkg::*;

  localparam int POR_W = $clog2(POR_CYCLES + 1);

  generate
    if (POR_CYCLES < 1)
    begin : g_bad_por
      $error("POR_CYCLES must be at least one");
    end
  endgenerate

  logic [POR_W-1:0]  por_cnt_reg;
  logic [POR_W-1:0]  por_cnt_next;
  logic              rst_n_reg;
  logic              rst_n_next;
  logic              ppi_rst_reg;
  logic              ppi_rst_next;
  logic [1:0]        slot_reg;
  logic [1:0]        slot_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] vec_reg;
  logic              wr_prev_reg;
  logic              wv_reg;
  logic              wv_next;
  logic              wio_reg;
  logic              wio_next;
  logic [ADDR_W-1:0] waddr_reg;
  logic [ADDR_W-1:0] waddr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic              ack;

  assign ack = ~bus.io_request_n & ~bus.opcode_fetch_n;

  always_comb
  begin
    por_cnt_next = por_cnt_reg;
    rst_n_next   = rst_n_reg;
    if (!rst_n_reg)
    begin
      por_cnt_next = POR_W'(por_cnt_reg + 1'b1);
      if (por_cnt_reg == POR_W'(POR_CYCLES - 1))
        rst_n_next = 1'b1;
    end
    ppi_rst_next = ~rst_n_next;
    slot_next    = slot_reg;
    if (!rst_n_reg)
      slot_next = SLOT_RESET;
    else if (slot_load_i)
      slot_next = slot_sel_i;
    wv_next    = 1'b0;
    wio_next   = wio_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    if (wr_prev_reg && !bus.store_strobe_n)
    begin
      wv_next    = 1'b1;
      wio_next   = ~bus.io_request_n;
      waddr_next = bus.addr;
      wdata_next = bus.data;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      por_cnt_reg <= '0;
      rst_n_reg   <= 1'b0;
      ppi_rst_reg <= 1'b1;
      slot_reg    <= SLOT_RESET;
      rdata_reg   <= '0;
      vec_reg     <= '0;
      wr_prev_reg <= 1'b1;
      wv_reg      <= 1'b0;
      wio_reg     <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
    end
    else
    begin
      por_cnt_reg <= por_cnt_next;
      rst_n_reg   <= rst_n_next;
      ppi_rst_reg <= ppi_rst_next;
      slot_reg    <= slot_next;
      rdata_reg   <= rdata_i;
      vec_reg     <= int_vector_i;
      wr_prev_reg <= bus.store_strobe_n;
      wv_reg      <= wv_next;
      wio_reg     <= wio_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
    end
  end

  cbc_wait_gen u_wait
  (
    .core_clk_i       (core_clk_i),
    .reset_i          (reset_i),
    .opcode_fetch_n_i (bus.opcode_fetch_n),
    .wait_n_o         (bus.wait_n)
  );

  assign bus.sys_reset_n = rst_n_reg;
  // decoders qualify with the strobes since low address bits are shared
  assign boot_rom_select_n_o = ~(slot_reg == SLOT_BOOT && !bus.memory_request_n && !bus.read_n
                                 && bus.refresh_cycle_n && !bus.addr[ROM_ADDR_BIT]);
  assign mem_select_n_o      = ~(~bus.memory_request_n & bus.refresh_cycle_n);
  assign io_select_n_o       = ~(~bus.io_request_n & bus.opcode_fetch_n);
  assign buffer_toward_cpu_o = ~bus.read_n | ack;
  assign bus.ctl_data_oe     = (~bus.read_n & (~bus.memory_request_n | ~bus.io_request_n)) | ack;
  assign bus.ctl_data        = ack ? vec_reg : rdata_reg;
  assign slot_select_o       = slot_reg;
  assign ppi_reset_o         = ppi_rst_reg;
  assign int_ack_o           = ack;
  assign write_valid_o       = wv_reg;
  assign write_is_io_o       = wio_reg;
  assign write_addr_o        = waddr_reg;
  assign write_data_o        = wdata_reg;
endmodule

/* File: cbc_cpu_end.sv */
// Purpose: cpu end: machine cycle and t-state sequencer driving the control bus
// Assumes: bus inputs synchronous to core_clk_i; wait sampled on the falling edge
// Notes:   a small opcode set is decoded; other opcodes take one machine cycle
`timescale 1ns/1ns
//
// Overview of operation
// - fetch strobe low in every first cycle
// - absolute load: fetch, two operands, data read
// - instructions take one to four machine cycles
// - each state lasts one clock period
// - refresh only in fetch states three, four
// - memory request low with refresh strobe
// - refresh row counter drives address, advances
// - interrupt ack: fetch and io strobes low
// - memory and io requests never both low
// - strobes separate memory and io spaces
// - read strobe inbound, store strobe outbound
// - bus buffers turn toward cpu on read strobe or int ack
// - reset clears pc, page, row, interrupts, mode
// - no bus activity while reset low
// - power-on reset held about 200 ms
// - reset selects slot zero boot rom
// - parallel port chip gets inverted reset
// - wait low inserts one held stall state
// - wait on falling edge, fetch on rising
// - stalls continue while wait stays low
// - controller makes one stall per fetch
module cbc_cpu_end #(
  parameter int MAX_MCYCLES = 6
)
(
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  cbc_bus_if.cpu_end                      bus,
  input  wire logic                       int_req_n_i,
  output logic [cbc_pkg::DATA_W-1:0]      acc_o,
  output logic [cbc_pkg::ADDR_W-1:0]      pc_o,
  output logic                            int_enable_o,
  output logic [1:0]                      int_mode_o,
  output logic [7:0]                      int_page_o,
  output logic [7:0]                      refresh_row_o,
  output logic                            inserted_stall_state_o,
  output logic                            instr_done_o
);
  import cbc_pkg::*;

  generate
    if (MAX_MCYCLES < 4 || MAX_MCYCLES > 7)
    begin : g_bad_mcyc
      $error("MAX_MCYCLES must lie in 4..7");
    end
  endgenerate

  cbc_tstate_t       t_reg;
  cbc_tstate_t       t_next;
  cbc_mcycle_t       kind_reg;
  cbc_mcycle_t       kind_next;
  logic [2:0]        mcyc_reg;
  logic [2:0]        mcyc_next;
  logic              run_reg;
  logic              run_next;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [7:0]        op_reg;
  logic [7:0]        op_next;
  logic [7:0]        lo_reg;
  logic [7:0]        lo_next;
  logic [7:0]        hi_reg;
  logic [7:0]        hi_next;
  logic [7:0]        acc_reg;
  logic [7:0]        acc_next;
  logic [7:0]        dout_reg;
  logic [7:0]        dout_next;
  logic              ie_reg;
  logic              ie_next;
  logic [1:0]        im_reg;
  logic [1:0]        im_next;
  logic [7:0]        ipage_reg;
  logic [7:0]        ipage_next;
  logic [7:0]        row_reg;
  logic [7:0]        row_next;
  logic              done_reg;
  logic              done_next;
  logic              wait_smp_reg;
  logic              stall;
  logic              fetchlike;
  logic              t12;
  logic              end_cyc;
  logic [2:0]        idx;
  logic [ADDR_W-1:0] pc_after;

  assign fetchlike = (kind_reg == MC_FETCH) || (kind_reg == MC_INT_ACK);
  assign t12       = (t_reg == T1) || (t_reg == T2);
  assign stall     = run_reg && (t_reg == T2) && !wait_smp_reg;

  // wait is looked at half way through the state
  always_ff @(negedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      wait_smp_reg <= 1'b1;
    else
      wait_smp_reg <= bus.wait_n;
  end

  always_comb
  begin
    t_next     = t_reg;
    kind_next  = kind_reg;
    mcyc_next  = mcyc_reg;
    run_next   = run_reg;
    pc_next    = pc_reg;
    addr_next  = addr_reg;
    op_next    = op_reg;
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    acc_next   = acc_reg;
    dout_next  = dout_reg;
    ie_next    = ie_reg;
    im_next    = im_reg;
    ipage_next = ipage_reg;
    row_next   = row_reg;
    done_next  = 1'b0;
    end_cyc    = 1'b0;
    idx        = 3'(mcyc_reg + 3'h1);
    pc_after   = pc_reg;
    if (!bus.sys_reset_n)
    begin
      run_next   = 1'b0;
      t_next     = T1;
      kind_next  = MC_FETCH;
      mcyc_next  = MCYC_FETCH;
      pc_next    = PC_RESET;
      addr_next  = PC_RESET;
      ie_next    = 1'b0;
      im_next    = IM_RESET;
      ipage_next = IPAGE_RESET;
      row_next   = ROW_RESET;
    end
    else if (!run_reg)
    begin
      run_next  = 1'b1;
      addr_next = pc_reg;
    end
    else if (!stall)
    begin
      case (t_reg)
        T1: t_next = T2;
        T2:
        begin
          t_next = T3;
          case (kind_reg)
            MC_FETCH:
            begin
              op_next = bus.data;
              pc_next = 16'(pc_reg + 16'h1);
            end
            MC_INT_ACK: op_next = bus.data;
            MC_MEM_RD:
            begin
              if (mcyc_reg == MCYC_OPND1)
                lo_next = bus.data;
              else if (mcyc_reg == MCYC_OPND2)
                hi_next = bus.data;
              else
                acc_next = bus.data;
              if (mcyc_reg != MCYC_DATA)
                pc_next = 16'(pc_reg + 16'h1);
            end
            MC_IO_RD: acc_next = bus.data;
            default: t_next = T3;
          endcase
          if (fetchlike)
            addr_next = {ipage_reg, row_reg};
        end
        T3:
        begin
          if (fetchlike)
            t_next = T4;
          else
            end_cyc = 1'b1;
        end
        T4:
        begin
          row_next = {row_reg[ROW_W], ROW_W'(row_reg[ROW_W-1:0] + 7'h1)};
          end_cyc  = 1'b1;
        end
        default: t_next = T1;
      endcase
    end
    if (end_cyc)
    begin
      t_next = T1;
      if (idx < cbc_cycle_count(op_reg) && idx < 3'(MAX_MCYCLES))
      begin
        kind_next = cbc_cycle_kind(op_reg, idx);
        mcyc_next = idx;
        dout_next = acc_reg;
        if (idx == MCYC_DATA)
          addr_next = {hi_reg, lo_reg};
        else if (cbc_cycle_kind(op_reg, idx) == MC_IO_RD || cbc_cycle_kind(op_reg, idx) == MC_IO_WR)
          addr_next = {acc_reg, lo_reg};
        else
          addr_next = pc_reg;
      end
      else
      begin
        done_next = 1'b1;
        mcyc_next = MCYC_FETCH;
        pc_after  = pc_reg;
        addr_next = pc_after;
        if (op_reg == OP_EI)
          ie_next = 1'b1;
        else if (op_reg == OP_DI)
          ie_next = 1'b0;
        if (!int_req_n_i && ie_reg && op_reg != OP_EI && op_reg != OP_DI)
        begin
          kind_next = MC_INT_ACK;
          ie_next   = 1'b0;
        end
        else
          kind_next = MC_FETCH;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      t_reg     <= T1;
      kind_reg  <= MC_FETCH;
      mcyc_reg  <= MCYC_FETCH;
      run_reg   <= 1'b0;
      pc_reg    <= PC_RESET;
      addr_reg  <= PC_RESET;
      op_reg    <= 8'h00;
      lo_reg    <= 8'h00;
      hi_reg    <= 8'h00;
      acc_reg   <= ACC_RESET;
      dout_reg  <= 8'h00;
      ie_reg    <= 1'b0;
      im_reg    <= IM_RESET;
      ipage_reg <= IPAGE_RESET;
      row_reg   <= ROW_RESET;
      done_reg  <= 1'b0;
    end
    else
    begin
      t_reg     <= t_next;
      kind_reg  <= kind_next;
      mcyc_reg  <= mcyc_next;
      run_reg   <= run_next;
      pc_reg    <= pc_next;
      addr_reg  <= addr_next;
      op_reg    <= op_next;
      lo_reg    <= lo_next;
      hi_reg    <= hi_next;
      acc_reg   <= acc_next;
      dout_reg  <= dout_next;
      ie_reg    <= ie_next;
      im_reg    <= im_next;
      ipage_reg <= ipage_next;
      row_reg   <= row_next;
      done_reg  <= done_next;
    end
  end

  // strobes decode from state only, so a stall holds them unchanged
  assign bus.opcode_fetch_n   = ~(run_reg & fetchlike & t12);
  assign bus.memory_request_n = ~(run_reg & (((kind_reg == MC_FETCH) & t12)
                                  | (fetchlike & ((t_reg == T3) | (t_reg == T4)))
                                  | (((kind_reg == MC_MEM_RD) | (kind_reg == MC_MEM_WR)) & t12)));
  assign bus.io_request_n     = ~(run_reg & (t_reg == T2) & ((kind_reg == MC_IO_RD)
                                  | (kind_reg == MC_IO_WR) | (kind_reg == MC_INT_ACK)));
  assign bus.read_n           = ~(run_reg & ((((kind_reg == MC_FETCH) | (kind_reg == MC_MEM_RD)) & t12)
                                  | ((kind_reg == MC_IO_RD) & (t_reg == T2))));
  assign bus.store_strobe_n   = ~(run_reg & (t_reg == T2)
                                  & ((kind_reg == MC_MEM_WR) | (kind_reg == MC_IO_WR)));
  assign bus.refresh_cycle_n  = ~(run_reg & fetchlike & ((t_reg == T3) | (t_reg == T4)));
  assign bus.cpu_data_oe      = run_reg & (t_reg != T4)
                                & ((kind_reg == MC_MEM_WR) | (kind_reg == MC_IO_WR));
  assign bus.cpu_data         = dout_reg;
  assign bus.addr             = addr_reg;

  assign acc_o                  = acc_reg;
  assign pc_o                   = pc_reg;
  assign int_enable_o           = ie_reg;
  assign int_mode_o             = im_reg;
  assign int_page_o             = ipage_reg;
  assign refresh_row_o          = row_reg;
  assign inserted_stall_state_o = stall;
  assign instr_done_o           = done_reg;
endmodule

/* File: cbc_bus_monitor.sv */
// Purpose: concurrent checks on the control bus joining the two ends
// Assumes: one clock; reset_i asynchronous, active high
// Notes:   the controller stalls every fetch by one state
`timescale 1ns/1ns
module cbc_bus_monitor
(
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic [15:0] addr,
  input wire logic        cpu_data_oe,
  input wire logic        opcode_fetch_n,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        read_n,
  input wire logic        store_strobe_n,
  input wire logic        refresh_cycle_n,
  input wire logic        wait_n,
  input wire logic        sys_reset_n
);
  logic [6:0] row_reg;
  logic [6:0] row_next;
  logic       seen_reg;
  logic       seen_next;
  logic       refresh_cycle_n_reg;
  logic       refresh_cycle_n_next;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // row shown by the previous refresh
  always_comb
  begin
    refresh_cycle_n_next = refresh_cycle_n;
    row_next  = row_reg;
    seen_next = seen_reg;
    if (!refresh_cycle_n && refresh_cycle_n_reg)
    begin
      row_next  = addr[6:0];
      seen_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      row_reg  <= 7'h00;
      seen_reg <= 1'b0;
      refresh_cycle_n_reg <= 1'b1;
    end
    else
    begin
      row_reg  <= row_next;
      seen_reg <= seen_next;
      refresh_cycle_n_reg <= refresh_cycle_n_next;
    end
  end

  sequence s_fetch_low;
    !opcode_fetch_n [*3];
  endsequence

  sequence s_refresh_pair;
    (opcode_fetch_n && !refresh_cycle_n) [*2] ##1 refresh_cycle_n;
  endsequence

  a_fetch_refresh: assert property ($fell(opcode_fetch_n) |-> s_fetch_low ##1 s_refresh_pair)
    else $error("refresh does not follow fetch");
  a_refresh_memory_request_n: assert property (!refresh_cycle_n |-> !memory_request_n && read_n && store_strobe_n)
    else $error("refresh without memory request");
  a_row_advance: assert property ($fell(refresh_cycle_n) && seen_reg |-> addr[6:0] == row_reg + 7'h01
    && addr[15:8] == 8'h00)
    else $error("refresh row did not advance");
  a_wait_pulse: assert property ($fell(opcode_fetch_n) |-> wait_n ##1 !wait_n ##1 wait_n)
    else $error("wait is not one state per fetch");
  a_stall_hold: assert property ($fell(opcode_fetch_n) |-> ##2 $stable(addr)
    && $stable({opcode_fetch_n, memory_request_n, io_request_n, read_n}))
    else $error("outputs moved in stall");
  a_req_exclusive: assert property (!(!memory_request_n && !io_request_n))
    else $error("memory and io requests both low");
  a_io_one_state: assert property (!io_request_n && opcode_fetch_n |->
    (read_n != store_strobe_n) ##1 io_request_n)
    else $error("io strobe malformed");
  a_store_drives: assert property (!store_strobe_n |-> cpu_data_oe && read_n)
    else $error("store without data drive");
  a_ack_after_fetch: assert property ($fell(io_request_n) && !opcode_fetch_n |-> $past(opcode_fetch_n) == 1'b0)
    else $error("acknowledge without fetch");
  a_quiet_reset: assert property (!sys_reset_n |-> &{opcode_fetch_n, memory_request_n, io_request_n, read_n,
    store_strobe_n, refresh_cycle_n})
    else $error("bus active in reset");
  a_boot_zero: assert property ($rose(sys_reset_n) |-> ##[1:2]
    (!opcode_fetch_n && !read_n && addr == 16'h0000))
    else $error("first fetch not at zero");
endmodule

/* File: cbc_tb_top.sv */
// Purpose: self-checking bench for both bus ends joined by the bus interface
// Assumes: shortened power-on count; bench memory is read only
// Notes:   random program data from a fixed seed, boundary addresses in round zero
`timescale 1ns/1ns
module cpu_bus_cycle_control_tb_top;
  import cbc_pkg::*;
  localparam int NR = 8;
  logic        core_clk_i;
  logic        reset_i;
  logic        int_req_n_i;
  logic [1:0]  slot_sel_i;
  logic        slot_load_i;
  logic [7:0]  rdata_i;
  logic [7:0]  int_vector_i;
  logic [7:0]  acc_o;
  logic [15:0] pc_o;
  logic        int_enable_o;
  logic [1:0]  int_mode_o;
  logic [7:0]  int_page_o;
  logic [7:0]  refresh_row_o;
  logic        stall_o;
  logic [1:0]  slot_select_o;
  logic        boot_n_o;
  logic        toward_o;
  logic        ppi_reset_o;
  logic        int_ack_o;
  logic        ms_n;
  logic        wr_valid;
  logic [24:0] wr_seen;
  logic [7:0]  mem [0:65535];
  logic [24:0] exp_q [$];
  logic [79:0] w;
  logic [15:0] a;
  logic [15:0] b;
  logic [7:0]  ref_acc;
  logic        chk_wr;
  int          fail_count;
  int          n_tests;
  int          i;
  int          j;

  cbc_bus_if cbc_bus_if_inst ();
  cbc_cpu_end cbc_cpu_end_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .bus(cbc_bus_if_inst),
    .int_req_n_i(int_req_n_i), .acc_o(acc_o), .pc_o(pc_o), .int_enable_o(int_enable_o), .int_mode_o(int_mode_o),
    .int_page_o(int_page_o), .refresh_row_o(refresh_row_o), .inserted_stall_state_o(stall_o), .instr_done_o());
  cbc_ctl_end #(.POR_CYCLES(4)) cbc_ctl_end_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .bus(cbc_bus_if_inst),
    .slot_sel_i(slot_sel_i), .slot_load_i(slot_load_i), .rdata_i(rdata_i), .int_vector_i(int_vector_i),
    .slot_select_o(slot_select_o), .boot_rom_select_n_o(boot_n_o), .mem_select_n_o(ms_n), .io_select_n_o(),
    .buffer_toward_cpu_o(toward_o), .ppi_reset_o(ppi_reset_o), .int_ack_o(int_ack_o), .write_valid_o(wr_valid),
    .write_is_io_o(wr_seen[24]), .write_addr_o(wr_seen[23:8]), .write_data_o(wr_seen[7:0]));
  cbc_bus_monitor cbc_bus_monitor_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr(cbc_bus_if_inst.addr),
    .cpu_data_oe(cbc_bus_if_inst.cpu_data_oe), .opcode_fetch_n(cbc_bus_if_inst.opcode_fetch_n),
    .memory_request_n(cbc_bus_if_inst.memory_request_n), .io_request_n(cbc_bus_if_inst.io_request_n),
    .read_n(cbc_bus_if_inst.read_n), .store_strobe_n(cbc_bus_if_inst.store_strobe_n),
    .refresh_cycle_n(cbc_bus_if_inst.refresh_cycle_n), .wait_n(cbc_bus_if_inst.wait_n),
    .sys_reset_n(cbc_bus_if_inst.sys_reset_n));

  task chk(input string nm, input logic [24:0] e, input logic [24:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reference run of the program: expected writes and final accumulator
  function automatic logic [7:0] ref_run(input int n);
    logic [15:0] pc;
    logic [15:0] ad;
    logic [7:0]  acc;
    logic [7:0]  op;
    pc = 16'h0000;
    acc = ACC_RESET;
    repeat (n)
    begin
      op = mem[pc];
      ad = {mem[pc + 16'h2], mem[pc + 16'h1]};
      case (op)
        OP_LD_A_ABS: acc = mem[ad];
        OP_LD_ABS_A: exp_q.push_back({1'b0, ad, acc});
        OP_IN_A:     acc = mem[{acc, ad[7:0]}];
        OP_OUT_A:    exp_q.push_back({1'b1, acc, ad[7:0], acc});
        default:     ;
      endcase
      pc = pc + ((op == OP_LD_A_ABS || op == OP_LD_ABS_A) ? 16'h3 : (op == OP_IN_A || op == OP_OUT_A) ? 16'h2 : 16'h1);
    end
    return acc;
  endfunction

  task chk_fetch(input logic boot);
    @(negedge cbc_bus_if_inst.opcode_fetch_n) @(negedge core_clk_i);
    chk("boot_sel", boot, boot_n_o);
    chk("mem_sel", 25'h0, ms_n);
    chk("toward_cpu", 25'h1, toward_o);
    @(negedge core_clk_i) #2;
    chk("stall", 25'h1, stall_o);
    @(negedge core_clk_i);
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(negedge core_clk_i) rdata_i <= mem[cbc_bus_if_inst.addr];

  always @(negedge core_clk_i)
    if (chk_wr && wr_valid === 1'b1)
      chk("write", (exp_q.size() > 0) ? exp_q.pop_front() : 25'h0, wr_seen);

  initial
  begin
    #200000;
    fail_count++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(69794));
    {reset_i, int_req_n_i, slot_load_i, chk_wr, fail_count, n_tests} = '0;
    reset_i = 1'b1;
    int_req_n_i = 1'b1;
    slot_sel_i = 2'h0;
    rdata_i = 8'h00;
    int_vector_i = 8'($urandom) & 8'h0f;
    for (i = 0; i < 65536; i++) mem[i] = i[15] ? 8'($urandom) : 8'h00;
    for (j = 0; j < NR; j++)
    begin
      a = (j == 0) ? 16'hffff : {1'b1, 15'($urandom)};
      b = (j == 0) ? 16'h8000 : {1'b1, 15'($urandom)};
      w = {OP_LD_A_ABS, a[7:0], a[15:8], OP_LD_ABS_A, b[7:0], b[15:8], OP_IN_A, 8'($urandom), OP_OUT_A,
        (j == 0) ? 8'hff : 8'($urandom)};
      for (i = 0; i < 10; i++) mem[10 * j + i] = w[79 - 8 * i -: 8];
    end
    mem[10 * NR] = OP_EI;
    ref_acc = ref_run(4 * NR);
    repeat (5) @(negedge core_clk_i);
    reset_i = 1'b0;
    chk("ppi_hold", 25'h1, ppi_reset_o);
    chk("slot", 25'h0, slot_select_o);
    chk_wr = 1'b1;
    chk_fetch(1'b0);
    while (exp_q.size() > 0) @(negedge core_clk_i);
    chk("acc", ref_acc, acc_o);
    chk("ppi_run", 25'h0, ppi_reset_o);
    while (int_enable_o !== 1'b1) @(negedge core_clk_i);
    int_req_n_i = 1'b0;
    while (int_ack_o !== 1'b1) @(negedge core_clk_i);
    chk("vector", int_vector_i, cbc_bus_if_inst.data);
    int_req_n_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    chk("ie_off", 25'h0, int_enable_o);
    slot_sel_i = 2'(1 + $urandom_range(2));
    slot_load_i = 1'b1;
    @(negedge core_clk_i);
    slot_load_i = 1'b0;
    chk("slot_load", slot_sel_i, slot_select_o);
    chk_fetch(1'b1);
    chk_wr = 1'b0;
    reset_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    chk("pc", 25'h0, pc_o);
    chk("regs", 25'h0, {int_enable_o, int_mode_o, int_page_o, refresh_row_o, slot_select_o});
    chk("ppi_again", 25'h1, ppi_reset_o);
    reset_i = 1'b0;
    chk_fetch(1'b0);
    wrap_up;
  end
endmodule
